// ==== logic/oass_pkg.sv ====
/*
 * Package for the amplifier source select register block: register offsets,
 * field layouts, select codes and the packed carrier types.
 * Assumes a single AHB-Lite slave with 32-bit data and word registers.
 */
package oass_pkg;

    // word byte offsets
    localparam logic [7:0] OASS_OFF_CTRL = 8'h00;
    localparam logic [7:0] OASS_OFF_ORS = 8'h04;
    localparam logic [7:0] OASS_OFF_NCH = 8'h08;
    localparam logic [7:0] OASS_OFF_PCH = 8'h0c;
    localparam logic [7:0] OASS_OFF_STAT = 8'h10;

    // field widths
    localparam int OASS_ORS_W = 5;
    localparam int OASS_CH_W = 4;

    // control register fields
    localparam int OASS_CTRL_EN_BIT = 7;
    localparam int OASS_CTRL_UG_BIT = 4;
    localparam int OASS_CTRL_POL_BIT = 2;
    localparam int OASS_CTRL_ORM_LSB = 0;
    localparam logic [7:0] OASS_CTRL_MASK = 8'h97;

    // reset values
    localparam logic [7:0] OASS_CTRL_RST = 8'h00;
    localparam logic [4:0] OASS_ORS_RST = 5'h00;
    localparam logic [3:0] OASS_CH_RST = 4'h0;

    // override source code bases
    localparam logic [4:0] OASS_ORS_CCP = 5'h00;
    localparam logic [4:0] OASS_ORS_PWM_A = 5'h04;
    localparam logic [4:0] OASS_ORS_PWM_B = 5'h08;
    localparam logic [4:0] OASS_ORS_CMP = 5'h0c;
    localparam logic [4:0] OASS_ORS_CMP_LAST = 5'h11;
    localparam logic [4:0] OASS_ORS_LC = 5'h14;
    localparam logic [4:0] OASS_ORS_WG_LO = 5'h18;
    localparam logic [4:0] OASS_ORS_WG_HI = 5'h1c;

    // channel codes
    localparam logic [3:0] OASS_CH_PIN0 = 4'h0;
    localparam logic [3:0] OASS_CH_PIN1 = 4'h1;
    localparam logic [3:0] OASS_CH_CONV1 = 4'h2;
    localparam logic [3:0] OASS_CH_CONV2 = 4'h3;
    localparam logic [3:0] OASS_CH_CONV3 = 4'h4;
    localparam logic [3:0] OASS_CH_CONV4 = 4'h5;
    localparam logic [3:0] OASS_CH_REFBUF = 4'h6;
    localparam logic [3:0] OASS_CH_RAMP1 = 4'h7;
    localparam logic [3:0] OASS_CH_RAMP2 = 4'h8;

    // one-hot analog mux select width: pins 2, converters 4, ref 1, ramps 2
    localparam int OASS_MUX_W = 9;

    // digital sources feeding the override gate
    typedef struct packed {
        logic [3:0] waveform_generator_channel_c;
        logic [3:0] waveform_generator_channel_b;
        logic [3:0] waveform_generator_channel_a;
        logic [3:0] logic_cell_output;
        logic [5:0] comparator_sync_output;
        logic [2:0] pwm_group_b;
        logic [2:0] pwm_group_a;
        logic [2:0] capture_compare_output;
    } oass_src_type;

    // configuration presented to the amplifier
    typedef struct packed {
        logic enable;
        logic unity_gain_select;
        logic [1:0] override_action_select;
        logic [OASS_MUX_W-1:0] inverting_sel;
        logic [OASS_MUX_W-1:0] noninverting_sel;
        logic override_active;
    } oass_amp_type;

endpackage

// ==== logic/oass_chan_decode.sv ====
/*
 * Decodes a 4-bit amplifier channel code into a one-hot analog mux select.
 * Assumes the code comes from a register on the same clock.
 */
`timescale 1ns/1ps
module oass_chan_decode
    import oass_pkg::*;
#(
    parameter int INSTANCE = 1
)
(
    // code in
    input wire logic [OASS_CH_W-1:0] code,
    // one-hot select out, all zero when reserved
    output logic [OASS_MUX_W-1:0] sel,
    output logic reserved
);

    // instance three lacks pin 1, converters two and four and ramp two
    always_comb
    begin
        sel = '0;
        reserved = 1'b0;
        if (INSTANCE == 3 && (code == OASS_CH_PIN1 || code == OASS_CH_CONV2 ||
            code == OASS_CH_CONV4 || code == OASS_CH_RAMP2))
        begin
            reserved = 1'b1;
        end
        else if (code <= OASS_CH_RAMP2)
        begin
            sel[code] = 1'b1;
        end
        else
        begin
            reserved = 1'b1;
        end
    end

endmodule

// ==== logic/oass_regs.sv ====
/*
 * Source select register bank for one amplifier instance, AHB-Lite slave.
 * Assumes a single master, word transfers, hclk at 20 MHz and the digital
 * override sources already synchronous to hclk.
 * The analog multiplexers and the override gate sit outside; they only see
 * one-hot selects and one registered override level, never a raw code.
 * Byte lanes are not decoded: every access is taken as a whole word.
 */
// Added by the designer: the AHB-Lite slave port and the register addresses.
// Contract
// - override codes 01100 to 10001 route comparators one to six in order
// - codes 0-2 pick capture units, 4-6 and 8-10 pick pwm groups
// - codes 10100-10111 logic cells, 11000 up waveform generator channels
// - codes 00011,00111,01011,10010,10011 reserved; 111xx reserved on instance three
// - inverting field bits 3:0 picks pins, converters, reference, ramps
// - non-inverting field uses the same code assignment
// - channel registers bits 7:4 ignore writes and read zero
// - channel fields read/write, reset to zero on every reset
// - polarity set: override while source high; clear: while low
// - override register bits 7:5 read zero, code in bits 4:0
`timescale 1ns/1ps
module oass_regs
    import oass_pkg::*;
#(
    parameter int INSTANCE = 1
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // digital override sources
    input wire oass_src_type sources,
    // amplifier configuration
    output oass_amp_type amp
);

    // elaboration check: only three amplifier instances exist
    if (INSTANCE < 1 || INSTANCE > 3)
    begin : g_bad_instance
        $error("oass_regs: INSTANCE must be 1 to 3");
    end

    // ahb address phase capture
    logic wr_pend_ff;
    logic nxt_wr_pend;
    logic [7:0] addr_ff;
    logic [7:0] nxt_addr;
    // software visible fields, unimplemented bits never stored
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [OASS_ORS_W-1:0] ors_ff;
    logic [OASS_ORS_W-1:0] nxt_ors;
    logic [OASS_CH_W-1:0] nch_ff;
    logic [OASS_CH_W-1:0] nxt_nch;
    logic [OASS_CH_W-1:0] pch_ff;
    logic [OASS_CH_W-1:0] nxt_pch;
    // read data and amplifier outputs, both straight from flops
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    oass_amp_type amp_ff;
    oass_amp_type nxt_amp;
    // decode results, combinational from the registered fields, the sources and the bus
    logic sel_src;
    logic ors_reserved;
    logic nch_reserved;
    logic pch_reserved;
    logic [OASS_MUX_W-1:0] nch_sel;
    logic [OASS_MUX_W-1:0] pch_sel;
    logic addr_phase;

    // nonseq and seq both carry bit 1; busy and idle are ignored
    // hsize is not checked, so a narrow write still lands as a full word
    // and clears the unused bits of the field
    assign addr_phase = hsel && hready && htrans[1];
    // zero wait states, never an error
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign amp = amp_ff;

    // override source mux; reserved codes give a low, inactive source
    // groups are tested from the top code down, so each branch only needs
    // its lower bound; the comparator window is tested first because it
    // straddles the 01111/10000 boundary and would otherwise split in two
    always_comb
    begin
        sel_src = 1'b0;
        ors_reserved = 1'b0;
        if (ors_ff >= OASS_ORS_CMP && ors_ff <= OASS_ORS_CMP_LAST)
        begin
            sel_src = sources.comparator_sync_output[3'(ors_ff - OASS_ORS_CMP)];
        end
        else if (ors_ff >= OASS_ORS_WG_HI)
        begin
            if (INSTANCE == 3)
            begin
                ors_reserved = 1'b1;
            end
            else
            begin
                sel_src = sources.waveform_generator_channel_b[ors_ff[1:0]];
            end
        end
        else if (ors_ff >= OASS_ORS_WG_LO)
        begin
            // instance three wires its own unit to the a/c slot via the c group
            if (INSTANCE == 3)
            begin
                sel_src = sources.waveform_generator_channel_c[ors_ff[1:0]];
            end
            else
            begin
                sel_src = sources.waveform_generator_channel_a[ors_ff[1:0]];
            end
        end
        else if (ors_ff >= OASS_ORS_LC)
        begin
            sel_src = sources.logic_cell_output[ors_ff[1:0]];
        end
        else if (ors_ff[1:0] == 2'b11)
        begin
            ors_reserved = 1'b1;
        end
        else if (ors_ff >= OASS_ORS_PWM_B)
        begin
            sel_src = sources.pwm_group_b[ors_ff[1:0]];
        end
        else if (ors_ff >= OASS_ORS_PWM_A)
        begin
            sel_src = sources.pwm_group_a[ors_ff[1:0]];
        end
        else
        begin
            sel_src = sources.capture_compare_output[ors_ff[1:0]];
        end
        // codes 10010 and 10011 fall here: above comparators, below logic cells
        if (ors_ff > OASS_ORS_CMP_LAST && ors_ff < OASS_ORS_LC)
        begin
            ors_reserved = 1'b1;
            sel_src = 1'b0;
        end
    end

    // one decoder per input; both share the same code table, so a
    // table fix lands on both inputs at once
    oass_chan_decode #(
        .INSTANCE(INSTANCE)
    ) u_nch (
        .code(nch_ff),
        .sel(nch_sel),
        .reserved(nch_reserved)
    );

    oass_chan_decode #(
        .INSTANCE(INSTANCE)
    ) u_pch (
        .code(pch_ff),
        .sel(pch_sel),
        .reserved(pch_reserved)
    );

    // register writes land in the data phase after the captured address
    // a read pipelined into that same data phase still sees the old value,
    // since read data is prepared from the flops at its address phase;
    // software that needs the new value reads one transfer later
    always_comb
    begin
        nxt_wr_pend = addr_phase && hwrite;
        nxt_addr = addr_phase ? haddr : addr_ff;
        nxt_ctrl = ctrl_ff;
        nxt_ors = ors_ff;
        nxt_nch = nch_ff;
        nxt_pch = pch_ff;
        if (wr_pend_ff)
        begin
            if (addr_ff == OASS_OFF_CTRL)
            begin
                nxt_ctrl = hwdata[7:0] & OASS_CTRL_MASK;
            end
            else if (addr_ff == OASS_OFF_ORS)
            begin
                nxt_ors = hwdata[OASS_ORS_W-1:0];
            end
            else if (addr_ff == OASS_OFF_NCH)
            begin
                nxt_nch = hwdata[OASS_CH_W-1:0];
            end
            else if (addr_ff == OASS_OFF_PCH)
            begin
                nxt_pch = hwdata[OASS_CH_W-1:0];
            end
        end
    end

    // read data prepared at the address phase, valid in the data phase
    // registering here costs a flop bank but keeps hrdata glitch free
    // and lets hreadyout stay tied high with no wait states
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (addr_phase && !hwrite)
        begin
            nxt_rdata = 32'h0000_0000;
            if (haddr == OASS_OFF_CTRL)
            begin
                nxt_rdata[7:0] = ctrl_ff;
            end
            else if (haddr == OASS_OFF_ORS)
            begin
                nxt_rdata[OASS_ORS_W-1:0] = ors_ff;
            end
            else if (haddr == OASS_OFF_NCH)
            begin
                nxt_rdata[OASS_CH_W-1:0] = nch_ff;
            end
            else if (haddr == OASS_OFF_PCH)
            begin
                nxt_rdata[OASS_CH_W-1:0] = pch_ff;
            end
            else if (haddr == OASS_OFF_STAT)
            begin
                nxt_rdata[3:0] = {amp_ff.override_active, ors_reserved,
                    pch_reserved, nch_reserved};
            end
        end
    end

    // registered amplifier outputs; polarity picks the active source level
    // the extra flop delays the override by one cycle, traded for an
    // output that cannot glitch while the source code is being rewritten
    always_comb
    begin
        nxt_amp.enable = ctrl_ff[OASS_CTRL_EN_BIT];
        nxt_amp.unity_gain_select = ctrl_ff[OASS_CTRL_UG_BIT];
        nxt_amp.override_action_select = ctrl_ff[OASS_CTRL_ORM_LSB +: 2];
        nxt_amp.inverting_sel = nch_sel;
        nxt_amp.noninverting_sel = pch_sel;
        if (ors_reserved)
        begin
            nxt_amp.override_active = 1'b0;
        end
        else
        begin
            nxt_amp.override_active = ctrl_ff[OASS_CTRL_POL_BIT] ? sel_src : !sel_src;
        end
    end

    // all state clears on any reset
    // power-on, brown-out and other resets all arrive on the one pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            ctrl_ff <= OASS_CTRL_RST;
            ors_ff <= OASS_ORS_RST;
            nch_ff <= OASS_CH_RST;
            pch_ff <= OASS_CH_RST;
            rdata_ff <= 32'h0000_0000;
            amp_ff <= '0;
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff <= nxt_addr;
            ctrl_ff <= nxt_ctrl;
            ors_ff <= nxt_ors;
            nch_ff <= nxt_nch;
            pch_ff <= nxt_pch;
            rdata_ff <= nxt_rdata;
            amp_ff <= nxt_amp;
        end
    end

endmodule

// ==== sim/oass_regs_props.sv ====
/*
 * Checker for oass_regs: shadows bus writes, then checks read data and mux outputs.
 * Assumes instance one, hready looped from hreadyout and word writes.
 */
`timescale 1ns/1ps
module oass_regs_props
    import oass_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // amplifier side
    input wire oass_src_type sources,
    input wire oass_amp_type amp
);
    logic wr_ff, rd_ff, pol_ff, eo_ff, nxt_wr, nxt_rd, nxt_pol, nxt_eo, rs;
    logic [7:0] a_ff;
    logic [4:0] o_ff, nxt_o;
    logic [3:0] n_ff, p_ff, nxt_n, nxt_p;
    logic [8:0] en_ff, ep_ff, nxt_en, nxt_ep;

    // reserved override codes
    assign rs = o_ff inside {5'h03, 5'h07, 5'h0b, 5'h12, 5'h13};

    // shadow registers; expected outputs lag one cycle like the amp flops
    always_comb
    begin
        nxt_wr = hsel && htrans[1] && hwrite;
        nxt_rd = hsel && htrans[1] && !hwrite;
        nxt_pol = wr_ff && a_ff == OASS_OFF_CTRL ? hwdata[2] : pol_ff;
        nxt_o = wr_ff && a_ff == OASS_OFF_ORS ? hwdata[4:0] : o_ff;
        nxt_n = wr_ff && a_ff == OASS_OFF_NCH ? hwdata[3:0] : n_ff;
        nxt_p = wr_ff && a_ff == OASS_OFF_PCH ? hwdata[3:0] : p_ff;
        nxt_en = n_ff > 4'h8 ? 9'h000 : 9'h001 << n_ff;
        nxt_ep = p_ff > 4'h8 ? 9'h000 : 9'h001 << p_ff;
        nxt_eo = sources.comparator_sync_output[o_ff - 5'h0c] ~^ pol_ff;
    end

    // both reset to zero, so amp and expectation start equal
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            {wr_ff, rd_ff, pol_ff, eo_ff, a_ff, o_ff, n_ff, p_ff, en_ff, ep_ff} <= '0;
        else
            {wr_ff, rd_ff, pol_ff, eo_ff, a_ff, o_ff, n_ff, p_ff, en_ff, ep_ff} <=
                {nxt_wr, nxt_rd, nxt_pol, nxt_eo, haddr, nxt_o, nxt_n, nxt_p, nxt_en, nxt_ep};
    end

    logic [3:0] k_ff;

    // control shadow: enable, unity gain and action fields
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            k_ff <= 4'h0;
        else if (wr_ff && a_ff == OASS_OFF_CTRL)
            k_ff <= {hwdata[7], hwdata[4], hwdata[1:0]};
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_nsel_map: assert property (amp.inverting_sel == en_ff)
        else $error("inverting select wrong");
    a_psel_map: assert property (amp.noninverting_sel == ep_ff)
        else $error("noninverting select wrong");
    a_cmp_route: assert property (
        $past(o_ff) inside {[5'h0c:5'h11]} |-> amp.override_active == eo_ff)
        else $error("comparator override wrong");
    a_rsvd_quiet: assert property (rs |=> !amp.override_active)
        else $error("reserved code overrides");
    a_nch_read: assert property (
        rd_ff && a_ff == OASS_OFF_NCH |-> hrdata == {28'h0, n_ff})
        else $error("inverting read wrong");
    a_pch_read: assert property (
        rd_ff && a_ff == OASS_OFF_PCH |-> hrdata == {28'h0, p_ff})
        else $error("noninverting read wrong");
    a_ors_read: assert property (
        rd_ff && a_ff == OASS_OFF_ORS |-> hrdata == {27'h0, o_ff})
        else $error("override read wrong");
    a_pol_read: assert property (
        rd_ff && a_ff == OASS_OFF_CTRL |-> hrdata[2] == pol_ff && hrdata[31:8] == 24'h0)
        else $error("control read wrong");

    a_ctrl_map: assert property (
        {amp.enable, amp.unity_gain_select, amp.override_action_select} == $past(k_ff))
        else $error("control outputs wrong");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not okay");

    c_rsvd: cover property (rs && pol_ff);
    c_cmp: cover property (amp.override_active && o_ff == 5'h11);
    c_read: cover property (rd_ff && a_ff == OASS_OFF_PCH);
endmodule

// ==== sim/oass_regs_tb_top.sv ====
/*
 * Top bench for oass_regs: ahb-lite master tasks, scoreboard queues, checker bind.
 * Assumes instance one with hready looped back from hreadyout.
 */
`timescale 1ns/1ps
module oass_regs_tb_top;
    import oass_pkg::*;
    logic hclk, hresetn, hsel, hwrite, pr, rd_ph, hreadyout, hresp, pl, rs, e_o, s;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r;
    logic [4:0] c;
    logic [8:0] e_n, e_p;
    oass_src_type src, sv;
    oass_amp_type amp;
    logic [31:0] q_rd[$];
    logic [18:0] q_amp[$];
    integer seed = 14, n_errors = 0, n_checks = 0, cyc = 0, i;

    oass_regs #(.INSTANCE(1)) oass_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sources(src), .amp(amp));

    // 50 ns clock
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one single transfer; waits on hready rather than assuming zero waits
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // notes the expected mux state and flags the watcher for one cycle
    task probe;
        @(posedge hclk);
        q_amp.push_back({e_n, e_p, e_o});
        pr <= 1'b1;
        @(posedge hclk);
        pr <= 1'b0;
    endtask

    // watcher: pops the oldest note whenever a result shows; also the hang limit
    always @(posedge hclk)
    begin
        if (rd_ph)
            chk(hrdata, q_rd.pop_front());
        if (pr)
            chk({13'h0, amp.inverting_sel, amp.noninverting_sel, amp.override_active},
                {13'h0, q_amp.pop_front()});
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            test_done;
        end
    end

    initial
    begin
        {hresetn, hsel, hwrite, pr, rd_ph, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        src = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        e_n = 9'h001;
        e_p = 9'h001;
        e_o = 1'b1;
        probe;
        rd(OASS_OFF_CTRL, 32'h0);
        rd(OASS_OFF_ORS, 32'h0);
        rd(OASS_OFF_NCH, 32'h0);
        rd(OASS_OFF_PCH, 32'h0);
        bus(1'b1, OASS_OFF_NCH, 32'hffffffff);
        bus(1'b1, OASS_OFF_PCH, 32'hffffffff);
        bus(1'b1, OASS_OFF_ORS, 32'hffffffff);
        bus(1'b1, OASS_OFF_CTRL, 32'hffffffff);
        bus(1'b1, 8'h20, 32'hffffffff);
        rd(OASS_OFF_NCH, 32'h0f);
        rd(OASS_OFF_PCH, 32'h0f);
        rd(OASS_OFF_ORS, 32'h1f);
        rd(OASS_OFF_CTRL, {24'h0, OASS_CTRL_MASK});
        rd(8'h20, 32'h0);
        $display("reset and field test done");
        // reserved override code keeps the gate quiet during the channel sweep
        bus(1'b1, OASS_OFF_ORS, 32'h3);
        e_o = 1'b0;
        for (i = 0; i < 16; i++)
        begin
            bus(1'b1, OASS_OFF_NCH, 32'(i));
            bus(1'b1, OASS_OFF_PCH, 32'(15 - i));
            rd(OASS_OFF_NCH, 32'(i));
            e_n = i > 8 ? 9'h000 : 9'h001 << i;
            e_p = 15 - i > 8 ? 9'h000 : 9'h001 << (15 - i);
            probe;
            rd(OASS_OFF_STAT, {28'h0, 2'b01, 1'(15 - i > 8), 1'(i > 8)});
        end
        $display("channel test done");
        for (i = 0; i < 64; i++)
        begin
            c = i[4:0];
            pl = i[5];
            r = $random(seed);
            sv = r[30:0];
            bus(1'b1, OASS_OFF_CTRL, {29'h0, pl, 2'h0});
            bus(1'b1, OASS_OFF_ORS, {27'h0, c});
            src <= sv;
            rs = c inside {5'h03, 5'h07, 5'h0b, 5'h12, 5'h13};
            // expected source straight from the code table, every group
            case (c[4:2])
                3'h0: s = sv.capture_compare_output[c[1:0]];
                3'h1: s = sv.pwm_group_a[c[1:0]];
                3'h2: s = sv.pwm_group_b[c[1:0]];
                3'h5: s = sv.logic_cell_output[c[1:0]];
                3'h6: s = sv.waveform_generator_channel_a[c[1:0]];
                3'h7: s = sv.waveform_generator_channel_b[c[1:0]];
                default: s = sv.comparator_sync_output[c - 5'h0c];
            endcase
            e_o = !rs && (s ~^ pl);
            probe;
        end
        $display("override test done");
        bus(1'b1, OASS_OFF_NCH, 32'h5);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        e_n = 9'h001;
        e_p = 9'h001;
        e_o = !sv.capture_compare_output[0];
        rd(OASS_OFF_NCH, 32'h0);
        probe;
        $display("second reset test done");
        test_done;
    end
endmodule

bind oass_regs oass_regs_props oass_regs_props_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sources(sources), .amp(amp));
